// ==== core/dtpb_pkg.sv ====
// Functional notes
// - counter counts down only while run enable is set; otherwise it holds
// - free-running, no reload: at zero the next tick loads all ones
// - free-running with reload: at zero the next tick loads the reload value
// - one-shot: counts down to zero and stops, reload select ignored
// - reload select matters only in free-running mode
// - polarity bit set makes the pwm waveform active low
// - pwm pin enable routes the waveform to the pin, else tone if enabled, else gpio
// - prescaler divides by two to the power rate+1; disable bit bypasses it
// - external source counts falling edges if edge select set, else rising
// - source select picks external pin when set, core tick otherwise
// - frame from 10-bit reload value when reload is selected, else 1024 ticks; duty from high bits plus duty byte
// - prescaler count register reads the live count, undisturbed
// - tone codes 0 to 7 take prescaler bits, dividing 2 up to 256
// - tone codes 8 to 15 take counter bits 0 to 7
// - counter read gives live value; write loads byte with reload high bits
// - comparator on the shared pin beats pwm and tone
package dtpb_pkg;
	localparam int CNT_W = 10;
	localparam int PS_W = 8;
	localparam logic [9:0] CNT_ALL_ONES = 10'h3ff;
	localparam logic [9:0] CNT_ZERO = 10'h000;
	// register indexes; byte address is index times four
	localparam logic [2:0] IDX_COUNT = 3'h0;
	localparam logic [2:0] IDX_CTL_A = 3'h1;
	localparam logic [2:0] IDX_CTL_B = 3'h2;
	localparam logic [2:0] IDX_DUTY = 3'h3;
	localparam logic [2:0] IDX_PS = 3'h4;
	localparam logic [2:0] IDX_TONE = 3'h5;
	localparam logic [2:0] IDX_HIGH = 3'h6;
	// control a fields
	localparam int A_RUN = 0;
	localparam int A_RELOAD = 1;
	localparam int A_ONESHOT = 2;
	localparam int A_ACT_LOW = 6;
	localparam int A_PIN_EN = 7;
	localparam logic [7:0] A_MASK = 8'hc7;
	// control b fields
	localparam int B_RATE_LSB = 0;
	localparam int B_PS_DIS_N = 3;
	localparam int B_EDGE = 4;
	localparam int B_SRC = 5;
	localparam logic [7:0] B_MASK = 8'h3f;
	// tone control fields
	localparam int T_EN = 7;
	localparam logic [7:0] T_MASK = 8'h8f;
	// high bits fields
	localparam int H_DUTY_LSB = 0;
	localparam int H_RLD_LSB = 4;
	localparam logic [7:0] H_MASK = 8'h33;
	// reset values
	localparam logic [7:0] RST_CTL_A = 8'h00;
	localparam logic [7:0] RST_CTL_B = 8'h3f;
	localparam logic [7:0] RST_PS = 8'hff;
	localparam logic [7:0] RST_TONE = 8'h0f;
	localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// ==== core/dtpb_timer.sv ====
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
module dtpb_timer (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic extCountPin,
	input wire logic cmpRouteEn,
	input wire logic cmpOut,
	input wire logic gpioOut,
	input wire logic gpioOe,
	output logic pwmWave,
	output logic toneOut,
	output logic pinOut,
	output logic pinOe
);
	logic [9:0] cnt_r, cnt_nxt;
	logic [7:0] rldLow_r, rldLow_nxt;
	logic [7:0] ctlA_r, ctlA_nxt;
	logic [7:0] ctlB_r, ctlB_nxt;
	logic [7:0] duty_r, duty_nxt;
	logic [7:0] ps_r, ps_nxt;
	logic [7:0] tone_r, tone_nxt;
	logic [7:0] high_r, high_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic wait_r, wait_nxt;
	logic ext1_r, ext2_r, ext3_r;
	logic cmp1_r, cmp2_r;
	logic pwm_r, pwm_nxt;
	logic tone_o_r, tone_o_nxt;
	logic pin_r, pin_nxt;
	logic oe_r, oe_nxt;
	logic req, acc, srcTick, tick, psOn;
	logic [7:0] psMask;
	logic [9:0] rldVal, dutyVal;
	logic [2:0] idx;
	logic [3:0] toneSel;

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign pwmWave = pwm_r;
	assign toneOut = tone_o_r;
	assign pinOut = pin_r;
	assign pinOe = oe_r;

	// bus decode and derived values
	assign req = avs_read | avs_write;
	assign acc = req & ~wait_r;
	assign idx = avs_address[4:2];
	assign psOn = ~ctlB_r[dtpb_pkg::B_PS_DIS_N];
	assign toneSel = tone_r[3:0];
	assign rldVal = {high_r[dtpb_pkg::H_RLD_LSB +: 2], rldLow_r};
	assign dutyVal = {high_r[dtpb_pkg::H_DUTY_LSB +: 2], duty_r};
	assign psMask = ~(8'hff << ({1'b0, ctlB_r[dtpb_pkg::B_RATE_LSB +: 3]}
		+ 4'h1));

	always_comb begin
		if (ctlB_r[dtpb_pkg::B_SRC]) begin
			if (ctlB_r[dtpb_pkg::B_EDGE])
				srcTick = ~ext2_r & ext3_r;
			else
				srcTick = ext2_r & ~ext3_r;
		end else begin
			srcTick = 1'b1;
		end
		if (psOn)
			tick = srcTick & ((ps_r & psMask) == 8'h00);
		else
			tick = srcTick;
	end

	// next values of registers, counter and prescaler
	always_comb begin
		cnt_nxt = cnt_r;
		rldLow_nxt = rldLow_r;
		ctlA_nxt = ctlA_r;
		ctlB_nxt = ctlB_r;
		duty_nxt = duty_r;
		tone_nxt = tone_r;
		high_nxt = high_r;
		rdata_nxt = rdata_r;
		ps_nxt = ps_r;
		// one wait cycle, then the answer
		wait_nxt = ~(req & wait_r);
		if (psOn && srcTick)
			ps_nxt = ps_r - 8'h01;
		if (ctlA_r[dtpb_pkg::A_RUN] && tick) begin
			if (cnt_r != dtpb_pkg::CNT_ZERO)
				cnt_nxt = cnt_r - 10'h001;
			else if (ctlA_r[dtpb_pkg::A_ONESHOT])
				cnt_nxt = cnt_r;
			else if (ctlA_r[dtpb_pkg::A_RELOAD])
				cnt_nxt = rldVal;
			else
				cnt_nxt = dtpb_pkg::CNT_ALL_ONES;
		end
		// read data prepared in the wait cycle
		if (req && wait_r) begin
			rdata_nxt = 32'h0000_0000;
			unique case (idx)
				dtpb_pkg::IDX_COUNT: rdata_nxt[7:0] = cnt_r[7:0];
				dtpb_pkg::IDX_CTL_A: rdata_nxt[7:0] = ctlA_r;
				dtpb_pkg::IDX_CTL_B: rdata_nxt[7:0] = ctlB_r;
				dtpb_pkg::IDX_PS: rdata_nxt[7:0] = ps_r;
				dtpb_pkg::IDX_HIGH: rdata_nxt[7:0] = high_r;
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
		// writes land on the accepting edge and beat counting
		if (acc && avs_write) begin
			unique case (idx)
				dtpb_pkg::IDX_COUNT: begin
					// load counter with reload high bits
					rldLow_nxt = avs_writedata[7:0];
					cnt_nxt = {high_r[dtpb_pkg::H_RLD_LSB +: 2],
						avs_writedata[7:0]};
				end
				dtpb_pkg::IDX_CTL_A:
					ctlA_nxt = avs_writedata[7:0] & dtpb_pkg::A_MASK;
				dtpb_pkg::IDX_CTL_B:
					ctlB_nxt = avs_writedata[7:0] & dtpb_pkg::B_MASK;
				dtpb_pkg::IDX_DUTY: duty_nxt = avs_writedata[7:0];
				dtpb_pkg::IDX_TONE:
					tone_nxt = avs_writedata[7:0] & dtpb_pkg::T_MASK;
				dtpb_pkg::IDX_HIGH:
					high_nxt = avs_writedata[7:0] & dtpb_pkg::H_MASK;
				default: ;
			endcase
		end
	end

	// next values of waveforms and the shared pin
	always_comb begin
		// active at or below duty, polarity applied
		pwm_nxt = (cnt_r <= dutyVal) ^ ctlA_r[dtpb_pkg::A_ACT_LOW];
		if (toneSel[3])
			tone_o_nxt = cnt_r[toneSel[2:0]];
		else
			tone_o_nxt = ps_r[toneSel[2:0]];
		tone_o_nxt = tone_o_nxt & tone_r[dtpb_pkg::T_EN];
		// comparator first, then pwm, then tone
		if (cmpRouteEn) begin
			pin_nxt = cmp2_r;
			oe_nxt = 1'b1;
		end else if (ctlA_r[dtpb_pkg::A_PIN_EN]) begin
			pin_nxt = pwm_nxt;
			oe_nxt = 1'b1;
		end else if (tone_r[dtpb_pkg::T_EN]) begin
			pin_nxt = tone_o_nxt;
			oe_nxt = 1'b1;
		end else begin
			pin_nxt = gpioOut;
			oe_nxt = gpioOe;
		end
	end

	// register stage, frozen while clkEn is low
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= dtpb_pkg::CNT_ZERO;
			rldLow_r <= dtpb_pkg::RST_BYTE;
			ctlA_r <= dtpb_pkg::RST_CTL_A;
			ctlB_r <= dtpb_pkg::RST_CTL_B;
			duty_r <= dtpb_pkg::RST_BYTE;
			ps_r <= dtpb_pkg::RST_PS;
			tone_r <= dtpb_pkg::RST_TONE;
			high_r <= dtpb_pkg::RST_BYTE;
			rdata_r <= 32'h0000_0000;
			wait_r <= 1'b1;
			ext1_r <= 1'b0;
			ext2_r <= 1'b0;
			ext3_r <= 1'b0;
			cmp1_r <= 1'b0;
			cmp2_r <= 1'b0;
			pwm_r <= 1'b0;
			tone_o_r <= 1'b0;
			pin_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (clkEn) begin
			cnt_r <= cnt_nxt;
			rldLow_r <= rldLow_nxt;
			ctlA_r <= ctlA_nxt;
			ctlB_r <= ctlB_nxt;
			duty_r <= duty_nxt;
			ps_r <= ps_nxt;
			tone_r <= tone_nxt;
			high_r <= high_nxt;
			rdata_r <= rdata_nxt;
			wait_r <= wait_nxt;
			ext1_r <= extCountPin;
			ext2_r <= ext1_r;
			ext3_r <= ext2_r;
			cmp1_r <= cmpOut;
			cmp2_r <= cmp1_r;
			pwm_r <= pwm_nxt;
			tone_o_r <= tone_o_nxt;
			pin_r <= pin_nxt;
			oe_r <= oe_nxt;
		end
	end

	// checks
	logic cntWr, runTick;
	assign cntWr = acc & avs_write & (idx == dtpb_pkg::IDX_COUNT);
	assign runTick = clkEn & ctlA_r[dtpb_pkg::A_RUN] & tick & ~cntWr;

	sequence s_req_start;
		clkEn && req && wait_r;
	endsequence
	sequence s_answer;
		!wait_r ##1 wait_r;
	endsequence

	a_hold_when_off: assert property (@(posedge core_clk) disable iff (sys_rst)
		clkEn && !ctlA_r[dtpb_pkg::A_RUN] && !cntWr |=> $stable(cnt_r))
		else $error("counter moved while disabled");
	a_count_down: assert property (@(posedge core_clk) disable iff (sys_rst)
		runTick && cnt_r != dtpb_pkg::CNT_ZERO
		|=> cnt_r == $past(cnt_r) - 10'h001)
		else $error("counter did not decrement");
	a_free_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
		runTick && cnt_r == dtpb_pkg::CNT_ZERO
		&& !ctlA_r[dtpb_pkg::A_ONESHOT] && !ctlA_r[dtpb_pkg::A_RELOAD]
		|=> cnt_r == dtpb_pkg::CNT_ALL_ONES)
		else $error("no wrap to all ones");
	a_reload_load: assert property (@(posedge core_clk) disable iff (sys_rst)
		runTick && cnt_r == dtpb_pkg::CNT_ZERO
		&& !ctlA_r[dtpb_pkg::A_ONESHOT] && ctlA_r[dtpb_pkg::A_RELOAD]
		|=> cnt_r == $past(rldVal))
		else $error("reload value not loaded");
	a_one_shot: assert property (@(posedge core_clk) disable iff (sys_rst)
		runTick && cnt_r == dtpb_pkg::CNT_ZERO
		&& ctlA_r[dtpb_pkg::A_ONESHOT] |=> cnt_r == dtpb_pkg::CNT_ZERO)
		else $error("one-shot did not stop");
	a_pwm_level: assert property (@(posedge core_clk) disable iff (sys_rst)
		clkEn |=> pwm_r == (($past(cnt_r) <= $past(dutyVal))
		^ $past(ctlA_r[dtpb_pkg::A_ACT_LOW])))
		else $error("pwm level wrong");
	a_ps_bypass: assert property (@(posedge core_clk) disable iff (sys_rst)
		clkEn && !psOn |=> $stable(ps_r))
		else $error("prescaler moved while disabled");
	a_tone_off: assert property (@(posedge core_clk) disable iff (sys_rst)
		clkEn && !tone_r[dtpb_pkg::T_EN] |=> !tone_o_r)
		else $error("tone active while disabled");
	a_pin_prio: assert property (@(posedge core_clk) disable iff (sys_rst)
		clkEn && cmpRouteEn |=> pin_r == $past(cmp2_r) && oe_r)
		else $error("comparator lost the pin");
	// bus answers one cycle after a request
	a_bus_answer: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_req_start ##1 clkEn |-> s_answer)
		else $error("bus answer late");
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
// compare two values, count it, report a mismatch at once
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	mismatches++; $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_top;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [4:0] adr = 5'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic wt;
	logic extPin = 1'b0;
	logic cmpEn = 1'b0;
	logic cmpV = 1'b0;
	logic gpo = 1'b0;
	logic gpe = 1'b0;
	logic clkEnable = 1'b1;
	logic pwm, tone, pout, poe;
	logic [7:0] q, v;
	int mismatches = 0;
	int samples_checked = 0;
	int cyc = 0;
	dtpb_timer i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.clkEn(clkEnable),
		.avs_address(adr), .avs_read(avsRead), .avs_write(avsWrite),
		.avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wt),
		.extCountPin(extPin), .cmpRouteEn(cmpEn), .cmpOut(cmpV),
		.gpioOut(gpo), .gpioOe(gpe), .pwmWave(pwm), .toneOut(tone),
		.pinOut(pout), .pinOe(poe));
	always #20 core_clk = ~core_clk;
	// hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// bus write, held until wait seen low
	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		@(posedge core_clk);
		adr <= {i, 2'b00};
		wdat <= {24'h0, d};
		avsWrite <= 1'b1;
		do @(posedge core_clk); while (wt !== 1'b0);
		avsWrite <= 1'b0;
	endtask
	// bus read, data taken at the completing edge
	task automatic rd(input logic [2:0] i, output logic [7:0] r);
		@(posedge core_clk);
		adr <= {i, 2'b00};
		avsRead <= 1'b1;
		do @(posedge core_clk); while (wt !== 1'b0);
		r = rdat[7:0];
		avsRead <= 1'b0;
	endtask
	task automatic t_reset();
		logic [7:0] e [1:7] = '{8'h00, 8'h3f, 8'h00, 8'hff, 8'h00, 8'h00,
			8'h00};
		for (int i = 1; i < 8; i++) begin
			rd(i[2:0], q);
			`CHK(q, e[i])
		end
		wr(3'h7, 8'h5a);
		rd(3'h7, q);
		`CHK(q, 8'h00)
		$display("test reset done");
	endtask
	task automatic t_hold();
		wr(3'h2, 8'h08);
		wr(3'h6, 8'h10);
		wr(3'h0, 8'h77);
		repeat (20) @(posedge core_clk);
		rd(3'h0, q);
		`CHK(q, 8'h77)
		$display("test hold done");
	endtask
	// clock enable low freezes the running counter
	task automatic t_freeze();
		wr(3'h0, 8'h40);
		wr(3'h1, 8'h01);
		clkEnable <= 1'b0;
		repeat (10) @(posedge core_clk);
		clkEnable <= 1'b1;
		wr(3'h1, 8'h00);
		rd(3'h0, q);
		`CHK(q, 8'h3d)
		$display("test freeze done");
	endtask
	task automatic t_wrap(input logic rl, input logic [7:0] lo, hi);
		wr(3'h6, 8'h00);
		wr(3'h0, 8'h0a);
		wr(3'h6, 8'h30);
		wr(3'h1, {6'h0, rl, 1'b1});
		repeat (15) @(posedge core_clk);
		wr(3'h1, 8'h00);
		rd(3'h0, q);
		`CHK(q >= lo && q <= hi, 1'b1)
		$display("test wrap done");
	endtask
	task automatic t_oneshot();
		wr(3'h6, 8'h00);
		wr(3'h0, 8'h20);
		wr(3'h1, 8'h07);
		repeat (60) @(posedge core_clk);
		rd(3'h0, q);
		`CHK(q, 8'h00)
		repeat (10) @(posedge core_clk);
		rd(3'h0, q);
		`CHK(q, 8'h00)
		wr(3'h1, 8'h00);
		$display("test oneshot done");
	endtask
	task automatic t_rate(input logic [7:0] b, lo, hi);
		// rate set only while prescaler disabled
		wr(3'h2, b | 8'h08);
		wr(3'h0, 8'h40);
		wr(3'h2, b);
		wr(3'h1, 8'h05);
		repeat (20) @(posedge core_clk);
		wr(3'h1, 8'h00);
		rd(3'h0, q);
		v = 8'h40 - q;
		`CHK(v >= lo && v <= hi, 1'b1)
		// disable first, then rate back to zero
		wr(3'h2, b | 8'h08);
		wr(3'h2, 8'h08);
		$display("test rate done");
	endtask
	// running prescaler reads live, one step per core cycle
	task automatic t_pscount();
		wr(3'h2, 8'h00);
		rd(3'h4, v);
		rd(3'h4, q);
		`CHK(v !== q, 1'b1)
		`CHK(v - q, 8'h03)
		$display("test pscount done");
	endtask
	task automatic t_pwm();
		wr(3'h6, 8'h00);
		wr(3'h0, 8'h10);
		wr(3'h3, 8'h20);
		wr(3'h1, 8'h80);
		repeat (4) @(posedge core_clk);
		`CHK({pwm, pout, poe}, 3'b111)
		wr(3'h1, 8'hc0);
		repeat (4) @(posedge core_clk);
		`CHK({pwm, pout}, 2'b00)
		wr(3'h3, 8'h0f);
		repeat (4) @(posedge core_clk);
		`CHK(pwm, 1'b1)
		wr(3'h6, 8'h01);
		repeat (4) @(posedge core_clk);
		`CHK(pwm, 1'b0)
		cmpEn <= 1'b1;
		cmpV <= 1'b1;
		repeat (5) @(posedge core_clk);
		`CHK({pout, poe}, 2'b11)
		wr(3'h1, 8'h00);
		cmpEn <= 1'b0;
		gpo <= 1'b1;
		repeat (4) @(posedge core_clk);
		`CHK({pout, poe}, 2'b10)
		$display("test pwm done");
	endtask
	task automatic t_tone();
		v = 8'ha5;
		wr(3'h6, 8'h00);
		wr(3'h0, v);
		for (int s = 0; s < 8; s++) begin
			wr(3'h5, 8'h88 | s[7:0]);
			repeat (3) @(posedge core_clk);
			`CHK(tone, v[s])
		end
		// freeze the prescaler, then tap each of its bits
		wr(3'h2, 8'h08);
		rd(3'h4, q);
		for (int s = 0; s < 8; s++) begin
			wr(3'h5, 8'h80 | s[7:0]);
			repeat (3) @(posedge core_clk);
			`CHK(tone, q[s])
		end
		wr(3'h5, 8'h0f);
		repeat (3) @(posedge core_clk);
		`CHK(tone, 1'b0)
		$display("test tone done");
	endtask
	// one rising and one falling pin edge while running
	task automatic t_ext(input logic fe, input logic [7:0] e);
		wr(3'h0, 8'h80);
		wr(3'h2, {2'b00, 1'b1, fe, 1'b1, 3'h0});
		wr(3'h1, 8'h01);
		extPin <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd(3'h0, q);
		`CHK(q, e)
		extPin <= 1'b0;
		repeat (8) @(posedge core_clk);
		rd(3'h0, q);
		`CHK(q, 8'h7f)
		wr(3'h1, 8'h00);
		$display("test ext done");
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_hold();
		t_freeze();
		t_wrap(1'b0, 8'he0, 8'hff);
		t_wrap(1'b1, 8'h00, 8'h0a);
		t_oneshot();
		t_rate(8'h08, 8'h12, 8'h1c);
		t_rate(8'h00, 8'h08, 8'h0f);
		t_rate(8'h07, 8'h00, 8'h01);
		t_pscount();
		t_pwm();
		t_tone();
		t_ext(1'b0, 8'h7f);
		t_ext(1'b1, 8'h80);
		end_of_test();
	end
endmodule
